/* File: verilog/brfep_regfile.sv */
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "brfep_defines.svh"
// What this block does
// (RL1) Holds 31 general registers and 6 status words of 32 bits.
// (RL2) Exposes indices 0 to 15 plus the current status word.
// (RL3) Indices 0 to 13 are plain storage without side effects.
// (RL4) Index 14 takes the return address on a branch with link.
// (RL5) Index 15 is the program counter, never banked.
// (RL6) Fast interrupt mode maps indices 8 to 14 to a private bank.
// (RL7) Supervisor, abort, undefined and normal interrupt modes bank only indices 13 and 14.
// (RL8) Banked index 14 takes return address on exception and link.
// (RL9) One current and five saved status words, saved one per mode.
// (RL10) Saved word holds flags and mode from exception entry.
// (RL11) Four result flags updated by flag-setting operations.
// (RL12) Sticky overflow set by saturation, cleared only by status write.
// (RL13) Condition evaluation never sees the sticky overflow flag.
// (RL14) Bytecode bit set means bytecode state, else compressed bit decides.
// (RL15) Five-bit mode field selects the mode and register bank.
// (RL16) Interrupt disable bits gate interrupt acceptance.
// (RL17) Each exception class enters a fixed privileged mode; reset and software trap share supervisor, aborts and breakpoint share abort.
// (RL18) Exception entry saves banked index 14 and saved word.
// (RL19) Priority: reset, data abort, fast, normal, prefetch, then traps.
// (RL20) Compressed state reaches only 0 to 7, stack, link, pc, status.
// (RL21) Entry copies status, forces mode, redirects fetch.
// (RL22) Breakpoint, undefined and software trap never pend together.
// (RL23) User and system modes share registers and have no saved word.
// (RL24) Index translation uses the current mode combinationally.
module brfep_regfile
  import brfep_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] rd_a_idx,
  output logic [31:0] rd_a_data,
  input wire logic [3:0] rd_b_idx,
  output logic [31:0] rd_b_data,
  input wire logic gpr_wr_en,
  input wire logic [3:0] gpr_wr_idx,
  input wire logic [31:0] gpr_wr_data,
  input wire logic branch_with_link,
  input wire logic [31:0] ret_addr,
  input wire logic flags_wr_en,
  input wire logic [3:0] flags_in,
  input wire logic sat_set,
  input wire logic status_write_instr,
  input wire logic status_wr_saved,
  input wire logic [31:0] status_wr_data,
  output logic [31:0] current_status_word,
  output logic [31:0] saved_status_word,
  output logic [3:0] cond_flags,
  output logic bytecode_state,
  output logic compressed_state,
  input wire logic exc_reset_req,
  input wire logic exc_dabt_req,
  input wire logic exc_fiq_req,
  input wire logic exc_irq_req,
  input wire logic exc_pabt_req,
  input wire logic exc_breakpoint_trap_req,
  input wire logic exc_undef_req,
  input wire logic exc_swi_req,
  output logic fetch_redirect,
  output brfep_exc_t exc_kind,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // (RL1) Register storage.
  brfep_state_t state_reg;
  brfep_state_t state_next;
  logic [4:0] mode;
  logic compressed;
  brfep_exc_t pick;

  // ****************************************************************
  // Index translation.
  // ****************************************************************
  function automatic logic [4:0] brfep_phys(input logic [3:0] idx,
                                            input logic [4:0] md);
    logic [4:0] p;
    // (RL5) Index 15 unbanked.
    p = {1'b0, idx};
    // (RL6) Fast bank select.
    if (md == `BRFEP_MODE_FIQ && idx >= 4'h8 && idx <= 4'hE) begin
      p = `BRFEP_PHYS_FIQ_BASE + {2'h0, idx[2:0]};
    end else if (idx == 4'hD || idx == 4'hE) begin
      // (RL7) Pair banking per mode.
      case (md)
        `BRFEP_MODE_SVC: p = `BRFEP_PHYS_SVC_SP + {4'h0, idx[0]};
        `BRFEP_MODE_ABT: p = `BRFEP_PHYS_ABT_SP + {4'h0, idx[0]};
        `BRFEP_MODE_UND: p = `BRFEP_PHYS_UND_SP + {4'h0, idx[0]};
        `BRFEP_MODE_IRQ: p = `BRFEP_PHYS_IRQ_SP + {4'h0, idx[0]};
        default: p = {1'b0, idx};
      endcase
    end
    return p;
  endfunction : brfep_phys

  function automatic logic [2:0] brfep_saved_idx(input logic [4:0] md);
    case (md)
      `BRFEP_MODE_FIQ: return 3'h0;
      `BRFEP_MODE_IRQ: return 3'h1;
      `BRFEP_MODE_SVC: return 3'h2;
      `BRFEP_MODE_ABT: return 3'h3;
      `BRFEP_MODE_UND: return 3'h4;
      default: return 3'h7;
    endcase
  endfunction : brfep_saved_idx

  function automatic logic [4:0] brfep_target(input brfep_exc_t k);
    case (k)
      BRFEP_EXC_DABT: return `BRFEP_MODE_ABT;
      BRFEP_EXC_PABT: return `BRFEP_MODE_ABT;
      BRFEP_EXC_BREAKPOINT_TRAP: return `BRFEP_MODE_ABT;
      BRFEP_EXC_FIQ: return `BRFEP_MODE_FIQ;
      BRFEP_EXC_IRQ: return `BRFEP_MODE_IRQ;
      BRFEP_EXC_UNDEF: return `BRFEP_MODE_UND;
      default: return `BRFEP_MODE_SVC;
    endcase
  endfunction : brfep_target

  function automatic logic brfep_access_ok(input logic [3:0] idx,
                                           input logic cmp);
    return !cmp || idx <= 4'h7 || idx >= 4'hD;
  endfunction : brfep_access_ok

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    logic [4:0] tmode;
    logic [2:0] sidx;
    tmode = `BRFEP_MODE_SVC;
    sidx = 3'h7;
    state_next = state_reg;
    state_next.exc_taken = 1'b0;
    state_next.exc_kind = BRFEP_EXC_NONE;
    // (RL15) Mode field drives bank selection.
    mode = state_reg.status[`BRFEP_MODE_HI:`BRFEP_MODE_LO];
    // (RL14) State bit decode.
    compressed = state_reg.status[`BRFEP_BIT_T] &
                 ~state_reg.status[`BRFEP_BIT_J];
    // (RL2) Sixteen visible indices.
    // (RL24) Reads use the current mode.
    state_next.rd_a = brfep_access_ok(rd_a_idx, compressed) ?
                      state_reg.gpr[brfep_phys(rd_a_idx, mode)] : 32'h0;
    state_next.rd_b = brfep_access_ok(rd_b_idx, compressed) ?
                      state_reg.gpr[brfep_phys(rd_b_idx, mode)] : 32'h0;
    // (RL9) Saved word only in its own mode.
    sidx = brfep_saved_idx(mode);
    state_next.rd_saved = (sidx != 3'h7) ? state_reg.saved[sidx] : 32'h0;
    // (RL3) Plain storage writes.
    // (RL20) Compressed state access limits.
    if (gpr_wr_en && brfep_access_ok(gpr_wr_idx, compressed)) begin
      state_next.gpr[brfep_phys(gpr_wr_idx, mode)] = gpr_wr_data;
    end
    // (RL4) Link register capture.
    // (RL8) Link capture in mode.
    if (branch_with_link) begin
      state_next.gpr[brfep_phys(4'hE, mode)] = ret_addr;
    end
    // (RL11) Result flag update.
    if (flags_wr_en) begin
      state_next.status[`BRFEP_BIT_N:`BRFEP_BIT_V] = flags_in;
    end
    if (status_write_instr) begin
      if (status_wr_saved) begin
        // (RL23) No saved word here.
        if (sidx != 3'h7) begin
          state_next.saved[sidx] = status_wr_data;
        end
      end else begin
        state_next.status = status_wr_data;
      end
    end
    // (RL12) Sticky set wins.
    if (sat_set) begin
      state_next.status[`BRFEP_BIT_Q] = 1'b1;
    end
    // (RL19) Fixed priority pick.
    pick = BRFEP_EXC_NONE;
    if (exc_reset_req) begin
      pick = BRFEP_EXC_RESET;
    end else if (state_reg.exc_enable) begin
      if (exc_dabt_req) begin
        pick = BRFEP_EXC_DABT;
      // (RL16) Interrupt disable gating.
      end else if (exc_fiq_req && !state_reg.status[`BRFEP_BIT_F]) begin
        pick = BRFEP_EXC_FIQ;
      end else if (exc_irq_req && !state_reg.status[`BRFEP_BIT_I]) begin
        pick = BRFEP_EXC_IRQ;
      end else if (exc_pabt_req) begin
        pick = BRFEP_EXC_PABT;
      // (RL22) Lowest traps are exclusive.
      end else if (exc_breakpoint_trap_req) begin
        pick = BRFEP_EXC_BREAKPOINT_TRAP;
      end else if (exc_undef_req) begin
        pick = BRFEP_EXC_UNDEF;
      end else if (exc_swi_req) begin
        pick = BRFEP_EXC_SWI;
      end
    end
    if (pick != BRFEP_EXC_NONE) begin
      // (RL17) Target mode entry.
      tmode = brfep_target(pick);
      // (RL10) Saved flags and mode.
      // (RL21) Save, force mode, redirect.
      state_next.saved[brfep_saved_idx(tmode)] = state_next.status;
      // (RL18) Banked link capture.
      state_next.gpr[brfep_phys(4'hE, tmode)] = ret_addr;
      state_next.status[`BRFEP_MODE_HI:`BRFEP_MODE_LO] = tmode;
      state_next.status[`BRFEP_BIT_I] = 1'b1;
      state_next.status[`BRFEP_BIT_T] = 1'b0;
      state_next.status[`BRFEP_BIT_J] = 1'b0;
      if (pick == BRFEP_EXC_FIQ || pick == BRFEP_EXC_RESET) begin
        state_next.status[`BRFEP_BIT_F] = 1'b1;
      end
      state_next.exc_taken = 1'b1;
      state_next.exc_kind = pick;
      state_next.last_exc = pick;
    end
    // Bus slave: address phase capture and read data.
    state_next.ap_valid = hsel && htrans[1] && hready;
    state_next.ap_write = hwrite;
    state_next.ap_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        `BRFEP_OFF_STATUS: state_next.hrdata = state_reg.status;
        `BRFEP_OFF_SAVED: state_next.hrdata = state_next.rd_saved;
        `BRFEP_OFF_CTRL: state_next.hrdata = {31'h0, state_reg.exc_enable};
        `BRFEP_OFF_LAST_EXC: state_next.hrdata = {28'h0, state_reg.last_exc};
        default: state_next.hrdata = 32'h0;
      endcase
    end
    if (state_reg.ap_valid && state_reg.ap_write &&
        state_reg.ap_addr == `BRFEP_OFF_CTRL) begin
      state_next.exc_enable = hwdata[0];
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
      state_reg.status <= `BRFEP_STATUS_RESET;
      state_reg.exc_enable <= `BRFEP_CTRL_RESET;
      state_reg.exc_kind <= BRFEP_EXC_NONE;
      state_reg.last_exc <= BRFEP_EXC_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign rd_a_data = state_reg.rd_a;
  assign rd_b_data = state_reg.rd_b;
  assign current_status_word = state_reg.status;
  assign saved_status_word = state_reg.rd_saved;
  // (RL13) Flags without the sticky bit.
  assign cond_flags = state_reg.status[`BRFEP_BIT_N:`BRFEP_BIT_V];
  assign bytecode_state = state_reg.status[`BRFEP_BIT_J];
  assign compressed_state = compressed;
  assign fetch_redirect = state_reg.exc_taken;
  assign exc_kind = state_reg.exc_kind;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.hrdata;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_exc_mode_entry: assert property ( // RL17
    fetch_redirect |-> current_status_word[4:0] == brfep_target(exc_kind))
    else $error("exception did not enter its mode");

  a_link_on_entry: assert property ( // RL18
    fetch_redirect |-> state_reg.gpr[brfep_phys(4'hE,
      current_status_word[4:0])] == $past(ret_addr))
    else $error("banked link not captured");

  a_saved_copy: assert property ( // RL21
    (!flags_wr_en && !status_write_instr && !sat_set) ##1 fetch_redirect
    |-> state_reg.saved[brfep_saved_idx(current_status_word[4:0])]
        == $past(current_status_word))
    else $error("saved word does not match prior status");

  a_dabt_first: assert property ( // RL19
    (exc_dabt_req && !exc_reset_req && state_reg.exc_enable)
    |=> exc_kind == BRFEP_EXC_DABT)
    else $error("data abort lost priority");

  a_fiq_masked: assert property ( // RL16
    (exc_fiq_req && current_status_word[`BRFEP_BIT_F] && !exc_reset_req
     && !exc_dabt_req && !exc_irq_req && !exc_pabt_req && !exc_breakpoint_trap_req
     && !exc_undef_req && !exc_swi_req) |=> !fetch_redirect)
    else $error("masked fast interrupt taken");

  a_sat_sticky: assert property ( // RL12
    sat_set |=> current_status_word[`BRFEP_BIT_Q])
    else $error("sticky overflow not set");

  a_q_holds: assert property ( // RL12
    (current_status_word[`BRFEP_BIT_Q] && !status_write_instr)
    |=> current_status_word[`BRFEP_BIT_Q])
    else $error("sticky overflow cleared without status write");

  a_pc_shared: assert property ( // RL5
    (rd_a_idx == 4'hF && !(gpr_wr_en && gpr_wr_idx == 4'hF))
    ##1 (rd_a_idx == 4'hF) |=> rd_a_data == $past(rd_a_data, 1))
    else $error("program counter read differs between cycles");

  a_fiq_bank: assert property ( // RL6
    (current_status_word[4:0] == `BRFEP_MODE_FIQ && rd_b_idx == 4'h8
     && !compressed_state)
    |=> rd_b_data == $past(state_reg.gpr[`BRFEP_PHYS_FIQ_BASE]))
    else $error("fast bank not selected");

  a_redirect_kind: assert property ( // RL21
    fetch_redirect |-> exc_kind != BRFEP_EXC_NONE)
    else $error("redirect without exception kind");

  a_reset_first: assert property ( // RL19
    exc_reset_req |=> fetch_redirect && exc_kind == BRFEP_EXC_RESET)
    else $error("reset request not taken first");

  a_entry_word_state: assert property ( // RL14
    fetch_redirect |-> !bytecode_state && !compressed_state
      && current_status_word[`BRFEP_BIT_I])
    else $error("exception entry left wrong state");

  a_fiq_masks_fiq: assert property ( // RL16
    (fetch_redirect && exc_kind == BRFEP_EXC_FIQ)
    |-> current_status_word[`BRFEP_BIT_F])
    else $error("fast entry left fast interrupts open");

  a_no_user_saved: assert property ( // RL23
    (current_status_word[4:0] == `BRFEP_MODE_USR
     || current_status_word[4:0] == `BRFEP_MODE_SYS)
    |=> saved_status_word == 32'h0)
    else $error("saved word visible in user or system mode");

  a_compressed_hidden: assert property ( // RL20
    (compressed_state && rd_a_idx >= 4'h8 && rd_a_idx <= 4'hC)
    |=> rd_a_data == 32'h0)
    else $error("high register visible in compressed state");

  a_enable_gates: assert property ( // RL16
    (!state_reg.exc_enable && !exc_reset_req) |=> !fetch_redirect)
    else $error("exception taken while disabled");

  c_fiq_entry: cover property (fetch_redirect && exc_kind == BRFEP_EXC_FIQ);
  c_dabt_fiq: cover property (exc_dabt_req && exc_fiq_req ##1
    fetch_redirect);
  c_link_fiq: cover property (branch_with_link &&
    current_status_word[4:0] == `BRFEP_MODE_FIQ);
  c_bus_read: cover property (hsel && htrans[1] && !hwrite ##1 hready);
  c_reset_entry: cover property (fetch_redirect &&
    exc_kind == BRFEP_EXC_RESET);

endmodule : brfep_regfile

/* File: verilog/brfep_defines.svh */
`ifndef BRFEP_DEFINES_SVH
`define BRFEP_DEFINES_SVH

// ****************************************************************
// Mode field encodings.
// ****************************************************************
`define BRFEP_MODE_USR 5'h10
`define BRFEP_MODE_FIQ 5'h11
`define BRFEP_MODE_IRQ 5'h12
`define BRFEP_MODE_SVC 5'h13
`define BRFEP_MODE_ABT 5'h17
`define BRFEP_MODE_UND 5'h1B
`define BRFEP_MODE_SYS 5'h1F

// ****************************************************************
// Status word field positions.
// ****************************************************************
`define BRFEP_BIT_N 31
`define BRFEP_BIT_V 28
`define BRFEP_BIT_Q 27
`define BRFEP_BIT_J 24
`define BRFEP_BIT_I 7
`define BRFEP_BIT_F 6
`define BRFEP_BIT_T 5
`define BRFEP_MODE_HI 4
`define BRFEP_MODE_LO 0

// ****************************************************************
// Reset values.
// ****************************************************************
`define BRFEP_STATUS_RESET 32'h000000D3
`define BRFEP_CTRL_RESET 1'h1

// ****************************************************************
// Physical register layout.
// ****************************************************************
`define BRFEP_NUM_GPR 31
`define BRFEP_NUM_SAVED 5
`define BRFEP_PHYS_FIQ_BASE 5'h10
`define BRFEP_PHYS_SVC_SP 5'h17
`define BRFEP_PHYS_ABT_SP 5'h19
`define BRFEP_PHYS_UND_SP 5'h1B
`define BRFEP_PHYS_IRQ_SP 5'h1D

// ****************************************************************
// Bus register offsets.
// ****************************************************************
`define BRFEP_OFF_STATUS 8'h00
`define BRFEP_OFF_SAVED 8'h04
`define BRFEP_OFF_CTRL 8'h08
`define BRFEP_OFF_LAST_EXC 8'h0C

`endif

/* File: verilog/brfep_pkg.sv */
package brfep_pkg;

  typedef enum logic [3:0] {
    BRFEP_EXC_NONE,
    BRFEP_EXC_RESET,
    BRFEP_EXC_DABT,
    BRFEP_EXC_FIQ,
    BRFEP_EXC_IRQ,
    BRFEP_EXC_PABT,
    BRFEP_EXC_BREAKPOINT_TRAP,
    BRFEP_EXC_UNDEF,
    BRFEP_EXC_SWI
  } brfep_exc_t;

  typedef struct packed {
    logic [30:0][31:0] gpr;
    logic [4:0][31:0] saved;
    logic [31:0] status;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic [31:0] rd_saved;
    logic exc_taken;
    brfep_exc_t exc_kind;
    brfep_exc_t last_exc;
    logic exc_enable;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
  } brfep_state_t;

endpackage : brfep_pkg

/* File: verification/brfep_core_model.sv */
`timescale 1ns/1ps
module brfep_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] raise,
  output logic [7:0] req
);
  // ****
  // Exception requests.
  // ****
  // one trap pending.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= 8'h00;
    end else begin
      req <= {raise[7:5] & (~raise[7:5] + 3'h1), raise[4:0]};
    end
  end
endmodule : brfep_core_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "brfep_defines.svh"
module tb;
  import brfep_pkg::*;
  // ****
  // Signals and model.
  // ****
  logic hclk, hresetn, gpr_wr_en, branch_with_link, flags_wr_en, sat_set;
  logic status_write_instr, status_wr_saved, hsel, hwrite, hreadyout;
  logic hresp, fetch_redirect, bytecode_state, compressed_state, en;
  logic [3:0] rd_a_idx, rd_b_idx, gpr_wr_idx, flags_in, cond_flags;
  logic [31:0] rd_a_data, rd_b_data, gpr_wr_data, ret_addr, status_wr_data;
  logic [31:0] current_status_word, saved_status_word, haddr, hwdata;
  logic [31:0] hrdata, seed, mst, bd;
  logic [31:0] mreg [31];
  logic [31:0] msav [32];
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] raise, req;
  logic [4:0] ml [7];
  brfep_exc_t exc_kind;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  wire logic hready = hreadyout;
  brfep_regfile dut (
    .hclk, .hresetn, .rd_a_idx, .rd_a_data, .rd_b_idx, .rd_b_data,
    .gpr_wr_en, .gpr_wr_idx, .gpr_wr_data, .branch_with_link, .ret_addr,
    .flags_wr_en, .flags_in, .sat_set, .status_write_instr,
    .status_wr_saved, .status_wr_data, .current_status_word,
    .saved_status_word, .cond_flags, .bytecode_state, .compressed_state,
    .exc_reset_req(req[0]), .exc_dabt_req(req[1]), .exc_fiq_req(req[2]),
    .exc_irq_req(req[3]), .exc_pabt_req(req[4]), .exc_breakpoint_trap_req(req[5]),
    .exc_undef_req(req[6]), .exc_swi_req(req[7]), .fetch_redirect,
    .exc_kind, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata
  );
  brfep_core_model core (.hclk, .hresetn, .raise, .req);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  // ****
  // Tasks.
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int phys(logic [4:0] m, int i);
    if (m == `BRFEP_MODE_FIQ && i > 7 && i < 15) return i + 8;
    if (i < 13 || i > 14) return i;
    case (m)
      `BRFEP_MODE_SVC: return i + 10;
      `BRFEP_MODE_ABT: return i + 12;
      `BRFEP_MODE_UND: return i + 14;
      `BRFEP_MODE_IRQ: return i + 16;
      default: return i;
    endcase
  endfunction : phys
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    bd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task automatic sw(logic s, logic [31:0] d);
    @(posedge hclk);
    status_write_instr <= 1'b1;
    status_wr_saved <= s;
    status_wr_data <= d;
    @(posedge hclk);
    status_write_instr <= 1'b0;
    #1;
    if (!s) mst = d;
    else if (mst[3:0] != 4'hF && mst[3:0] != 4'h0) msav[mst[4:0]] = d;
  endtask : sw
  task automatic gw(int i, logic [31:0] d);
    @(posedge hclk);
    gpr_wr_en <= 1'b1;
    gpr_wr_idx <= 4'(i);
    gpr_wr_data <= d;
    @(posedge hclk);
    gpr_wr_en <= 1'b0;
    if (!(mst[5] && !mst[24] && i > 7 && i < 13)) mreg[phys(mst[4:0], i)] = d;
  endtask : gw
  task automatic rchk(int i);
    logic [31:0] e;
    e = mreg[phys(mst[4:0], i)];
    if (mst[5] && !mst[24] && i > 7 && i < 13) e = 32'h0;
    @(posedge hclk);
    rd_a_idx <= 4'(i);
    rd_b_idx <= 4'(i);
    @(posedge hclk);
    #1;
    chk("rd_a", e, rd_a_data);
    chk("rd_b", e, rd_b_data);
  endtask : rchk
  task automatic fl(logic [3:0] f, logic s);
    @(posedge hclk);
    flags_wr_en <= 1'b1;
    flags_in <= f;
    sat_set <= s;
    @(posedge hclk);
    flags_wr_en <= 1'b0;
    sat_set <= 1'b0;
    #1;
    mst[31:28] = f;
    mst[27] = mst[27] | s;
    chk("cond", {28'h0, f}, {28'h0, cond_flags});
    chk("status", mst, current_status_word);
  endtask : fl
  task automatic exc(logic [7:0] s);
    int k;
    logic [4:0] m;
    k = 0;
    for (int i = 7; i >= 0; i--) begin
      if (s[i] && (i == 0 || en) && !(i == 2 && mst[6]) &&
          !(i == 3 && mst[7])) k = i + 1;
    end
    @(posedge hclk);
    raise <= s;
    ret_addr <= rnd();
    @(posedge hclk);
    raise <= 8'h00;
    @(posedge hclk);
    #1;
    chk("redirect", 32'(k != 0), {31'h0, fetch_redirect});
    chk("kind", 32'(k), {28'h0, exc_kind});
    if (k != 0) begin
      case (k)
        1, 8: m = `BRFEP_MODE_SVC;
        3: m = `BRFEP_MODE_FIQ;
        4: m = `BRFEP_MODE_IRQ;
        7: m = `BRFEP_MODE_UND;
        default: m = `BRFEP_MODE_ABT;
      endcase
      msav[m] = mst;
      mst = (mst & 32'hFEFFFF40) | {27'h4, m};
      if (k == 1 || k == 3) mst[6] = 1'b1;
      mreg[phys(m, 14)] = ret_addr;
      chk("status", mst, current_status_word);
      rchk(14);
      chk("saved", msav[m], saved_status_word);
      bus(1'b0, 8'h0C, 32'h0);
      chk("last", 32'(k), bd);
      bus(1'b0, 8'h04, 32'h0);
      chk("bus saved", msav[m], bd);
    end
  endtask : exc
  task automatic bl();
    @(posedge hclk);
    branch_with_link <= 1'b1;
    ret_addr <= rnd();
    @(posedge hclk);
    branch_with_link <= 1'b0;
    mreg[phys(mst[4:0], 14)] = ret_addr;
    rchk(14);
  endtask : bl
  // ****
  // Test sequence.
  // ****
  initial begin
    seed = 32'h0073D3BB;
    {hresetn, gpr_wr_en, branch_with_link, flags_wr_en, sat_set} = '0;
    {status_write_instr, status_wr_saved, hsel, hwrite} = '0;
    {rd_a_idx, rd_b_idx, gpr_wr_idx, flags_in, htrans, raise} = '0;
    {gpr_wr_data, ret_addr, status_wr_data, haddr, hwdata} = '0;
    hsize = 3'h2;
    mst = `BRFEP_STATUS_RESET;
    en = 1'b1;
    foreach (mreg[i]) mreg[i] = 32'h0;
    foreach (msav[i]) msav[i] = 32'h0;
    ml = '{`BRFEP_MODE_USR, `BRFEP_MODE_FIQ, `BRFEP_MODE_IRQ,
      `BRFEP_MODE_SVC, `BRFEP_MODE_ABT, `BRFEP_MODE_UND, `BRFEP_MODE_SYS};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk("status", mst, current_status_word);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk("bus status", mst, bd);
    bus(1'b0, 8'h08, 32'h0);
    chk("ctrl", 32'h1, bd);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, bd);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      foreach (ml[j]) begin
        sw(1'b0, {27'h6, ml[j]});
        if (p == 0) sw(1'b1, rnd());
        for (int i = 0; i < 16; i++) begin
          if (p == 0) gw(i, rnd());
          rchk(i);
        end
        chk("saved", msav[ml[j]], saved_status_word);
      end
    end
    $display("test banking done");
    sw(1'b0, 32'h0000003F);
    chk("compressed", 32'h1, {31'h0, compressed_state});
    gw(10, rnd());
    rchk(10);
    sw(1'b0, 32'h0100003F);
    chk("bytecode", 32'h2, {30'h0, bytecode_state, compressed_state});
    rchk(10);
    $display("test state done");
    bd = rnd();
    fl(bd[3:0], 1'b1);
    fl(bd[7:4], 1'b0);
    sw(1'b0, mst & 32'hF7FFFFFF);
    chk("sticky", mst, current_status_word);
    foreach (ml[j]) begin
      sw(1'b0, {27'h6, ml[j]});
      bl();
    end
    $display("test flags and link done");
    for (int n = 0; n < 60; n++) begin
      bd = rnd();
      sw(1'b0, (bd & 32'hF8000000) | 32'h1F);
      exc({3'h1 << bd[6:5], bd[4:0]});
    end
    sw(1'b0, 32'h000000DF);
    exc(8'h0C);
    exc(8'h04);
    bus(1'b1, 8'h08, 32'h0);
    en = 1'b0;
    sw(1'b0, 32'h0000001F);
    exc(8'h3E);
    exc(8'h01);
    bus(1'b1, 8'h08, 32'h1);
    en = 1'b1;
    $display("test exceptions done");
    conclude();
  end
endmodule : tb
